// File: rtl/rtc_pwr_pkg.sv
// Purpose: Shared constants for the backup power mode and alarm logic
// Assumes: 32-bit APB data, one word per register
// Notes: Field positions are the low bit of each field
`default_nettype none
package rtc_pwr_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] TIME_OFF = 8'h08;
  localparam logic [7:0] DATE_OFF = 8'h0C;
  localparam logic [7:0] ALM_TIME_OFF = 8'h10;
  localparam logic [7:0] ALM_DATE_OFF = 8'h14;
  localparam logic [7:0] ALM_MASK_OFF = 8'h18;
  // Control fields
  localparam int LP_SEL_POS = 0;
  localparam int ALM_EN_POS = 1;
  localparam int REPEAT_POS = 2;
  localparam int PIN_OFF_BKP_POS = 3;
  localparam int FREQ_SEL_POS = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status fields
  localparam int ST_BACKUP_POS = 0;
  localparam int ST_LOSS_POS = 1;
  localparam int ST_ALARM_POS = 2;
  localparam int ST_TRIP_ON_POS = 3;
  // Time and date word fields
  localparam int SEC_POS = 0;
  localparam int MIN_POS = 8;
  localparam int HOUR_POS = 16;
  localparam int WDAY_POS = 24;
  localparam int DATE_POS = 0;
  localparam int MON_POS = 8;
  localparam int YEAR_POS = 16;
  // Calendar reset values
  localparam logic [4:0] DATE_RESET = 5'h01;
  localparam logic [3:0] MON_RESET = 4'h1;
  localparam logic [6:0] YEAR_LAST = 7'h63;
  // Time base
  localparam int OSC_HZ = 32768;
  localparam int ALARM_PULSE_MS = 250;
  localparam int ALARM_PULSE_TICKS = OSC_HZ * ALARM_PULSE_MS / 1000;
  localparam int FILTER_TICKS = 4;
  // Supply mode states
  typedef enum logic [1:0] {
    MAIN_SUPPLY = 2'b01,
    BACKUP_SUPPLY = 2'b10
  } supply_mode_t;
endpackage
`default_nettype wire

// File: rtl/rtc_freq_div.sv
// Purpose: Divides oscillator ticks into seconds and selectable clocks
// Assumes: oscTick is one clock wide, once per oscillator period
// Notes: Select 0 is off, 1 is the oscillator, 2..15 divided taps
`default_nettype none
module rtc_freq_div (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic oscTick,
  input wire logic oscLevel,
  input wire logic [3:0] freqSel,
  output logic secTick,
  output logic freqLevel
);
  typedef struct packed {
    logic [14:0] div;
    logic sec;
    logic lvl;
  } div_t;
  div_t s_q, s_d;

  // Free running divider; the taps feed both seconds and output clock
  always_comb begin
    s_d = s_q;
    s_d.sec = 1'b0;
    if (oscTick) begin
      s_d.div = s_q.div + 15'h0001;
      s_d.sec = (s_q.div == 15'h7FFF);
    end
    if (freqSel == 4'h0) begin
      s_d.lvl = 1'b1;
    end else if (freqSel == 4'h1) begin
      s_d.lvl = oscLevel;
    end else begin
      s_d.lvl = s_q.div[freqSel - 4'h2];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign secTick = s_q.sec;
  assign freqLevel = s_q.lvl;
endmodule
`default_nettype wire

// File: rtl/rtc_calendar.sv
// Purpose: Binary time and calendar counters with leap year handling
// Assumes: Year 0..99 stands for 2000..2099
// Notes: Loads from software take priority over a second tick
`default_nettype none
module rtc_calendar (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic secTick,
  input wire logic loadTime,
  input wire logic loadDate,
  input wire logic [31:0] wdata,
  output logic [5:0] sec,
  output logic [5:0] min,
  output logic [4:0] hour,
  output logic [2:0] wday,
  output logic [4:0] date,
  output logic [3:0] mon,
  output logic [6:0] year
);
  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] date;
    logic [3:0] mon;
    logic [6:0] year;
  } cal_t;
  cal_t c_q, c_d;
  logic [4:0] lastDay;

  always_comb begin
    unique case (c_q.mon)
      4'h2: lastDay = (c_q.year[1:0] == 2'b00) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: lastDay = 5'h1E;
      default: lastDay = 5'h1F;
    endcase
  end

  // Ripple carry through the fields, one second at a time
  always_comb begin
    c_d = c_q;
    if (loadTime) begin
      c_d.sec = wdata[rtc_pwr_pkg::SEC_POS +: 6];
      c_d.min = wdata[rtc_pwr_pkg::MIN_POS +: 6];
      c_d.hour = wdata[rtc_pwr_pkg::HOUR_POS +: 5];
      c_d.wday = wdata[rtc_pwr_pkg::WDAY_POS +: 3];
    end else if (loadDate) begin
      c_d.date = wdata[rtc_pwr_pkg::DATE_POS +: 5];
      c_d.mon = wdata[rtc_pwr_pkg::MON_POS +: 4];
      c_d.year = wdata[rtc_pwr_pkg::YEAR_POS +: 7];
    end else if (secTick) begin
      c_d.sec = c_q.sec + 6'h01;
      if (c_q.sec == 6'h3B) begin
        c_d.sec = 6'h00;
        c_d.min = c_q.min + 6'h01;
        if (c_q.min == 6'h3B) begin
          c_d.min = 6'h00;
          c_d.hour = c_q.hour + 5'h01;
          if (c_q.hour == 5'h17) begin
            c_d.hour = 5'h00;
            c_d.wday = (c_q.wday == 3'h6) ? 3'h0 : c_q.wday + 3'h1;
            c_d.date = c_q.date + 5'h01;
            if (c_q.date >= lastDay) begin
              c_d.date = rtc_pwr_pkg::DATE_RESET;
              c_d.mon = c_q.mon + 4'h1;
              if (c_q.mon == 4'hC) begin
                c_d.mon = rtc_pwr_pkg::MON_RESET;
                c_d.year = (c_q.year == rtc_pwr_pkg::YEAR_LAST) ? 7'h00 : c_q.year + 7'h01;
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      c_q <= '0;
      c_q.date <= rtc_pwr_pkg::DATE_RESET;
      c_q.mon <= rtc_pwr_pkg::MON_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  assign sec = c_q.sec;
  assign min = c_q.min;
  assign hour = c_q.hour;
  assign wday = c_q.wday;
  assign date = c_q.date;
  assign mon = c_q.mon;
  assign year = c_q.year;
endmodule
`default_nettype wire

// File: rtl/rtc_backup_power.sv
// Purpose: Supply mode selection, serial gating, alarm and shared pin
// Assumes: Comparator and oscillator inputs are synchronous to clock
// Notes: APB slave with zero wait states; read data is registered
//
// Local design decisions: the APB interface to the registers and the register offsets.
`default_nettype none
// What this block does
// - Go to backup when supply is below backup-minus-hysteresis and below trip.
// - Return to main when supply beats backup-plus-hysteresis or trip-plus-hysteresis.
// - In backup the serial clock is ignored and serial data never driven.
// - Calendar, alarm and divider keep running in backup.
// - Shared pin stays active in backup unless control disables it.
// - Flag total power loss at power-up so software sees lost time.
// - Low-power select skips the trip check and turns trip monitoring off.
// - Low-power mode enters backup when supply drops below backup, with hysteresis.
// - Low-power select resets to zero, the normal switching rule.
// - Frequency select field chooses alarm interrupt or frequency output.
// - Interrupt mode pulls the open-drain pin low on alarm.
// - Frequency mode drives a selected crystal-derived clock open-drain.
// - Alarm fires when enabled fields all match the current time.
// - Repeat mode pulses the pin on every later match.
// - Alarm event sets a pollable status flag.
// - Calendar runs through 2099 with automatic leap years.
// - Time base is a 32.768kHz crystal or external clock on the oscillator input.
module rtc_backup_power #(
  parameter int PULSE_TICKS = rtc_pwr_pkg::ALARM_PULSE_TICKS,
  parameter int FILTER_LEN = rtc_pwr_pkg::FILTER_TICKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscillator_input,
  input wire logic vddBelowBatLow,
  input wire logic vddAboveBatHigh,
  input wire logic vddBelowTrip,
  input wire logic vddAboveTripHigh,
  input wire logic totalLossDetect,
  output logic tripMonitorEnable,
  output logic backupMode,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaPullFromCore,
  output logic sclToCore,
  output logic sdaToCore,
  output logic sdaOut,
  output logic sdaOeN,
  output logic alarm_or_freq_pinOut,
  output logic alarm_or_freq_pinOeN
);
  typedef struct packed {
    logic oscPrev;
    rtc_pwr_pkg::supply_mode_t mode;
    logic [7:0] filt;
    logic lpSel;
    logic almEn;
    logic repeatMode;
    logic pinOffBkp;
    logic [3:0] freqSel;
    logic lossFlag;
    logic almFlag;
    logic [26:0] almTime;
    logic [22:0] almDate;
    logic [6:0] almMask;
    logic [15:0] pulseCnt;
    logic secSeen;
    logic lastMatch;
    logic [31:0] rdata;
    logic err;
    logic sdaOeN;
    logic sclGate;
    logic pinOeN;
  } st_t;
  st_t s_q, s_d;

  logic oscTick, secTick, freqLevel;
  logic wrAcc, setupRd;
  logic [5:0] sec, min;
  logic [4:0] hour, date;
  logic [2:0] wday;
  logic [3:0] mon;
  logic [6:0] year;
  logic [6:0] fieldHit;
  logic match;
  logic wantBackup, wantMain, wantChange;
  logic [31:0] timeWord, dateWord;
  logic addrOk;
  logic inBackup;
  logic nextBackup;

  // Oscillator pin is taken as synchronous; no extra stages
  // edge of oscillator level gives one tick per period
  assign oscTick = oscillator_input & ~s_q.oscPrev;
  assign inBackup = (s_q.mode == rtc_pwr_pkg::BACKUP_SUPPLY);

  // Register write strobe on the access edge, read decode in setup
  assign wrAcc = psel & penable & pwrite;
  assign setupRd = psel & ~penable;

  // calendar and divider have no backup gating
  rtc_freq_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .oscTick(oscTick),
    .oscLevel(s_q.oscPrev),
    .freqSel(s_q.freqSel),
    .secTick(secTick),
    .freqLevel(freqLevel)
  );

  rtc_calendar u_cal (
    .clock(clock),
    .rst_n(rst_n),
    .secTick(secTick),
    .loadTime(wrAcc && paddr == rtc_pwr_pkg::TIME_OFF),
    .loadDate(wrAcc && paddr == rtc_pwr_pkg::DATE_OFF),
    .wdata(pwdata),
    .sec(sec),
    .min(min),
    .hour(hour),
    .wday(wday),
    .date(date),
    .mon(mon),
    .year(year)
  );

  assign timeWord = {5'h00, wday, 3'h0, hour, 2'h0, min, 2'h0, sec};
  assign dateWord = {9'h000, year, 4'h0, mon, 3'h0, date};

  // per-field compare; a masked-off field always hits
  always_comb begin
    fieldHit[0] = ~s_q.almMask[0] | (sec == s_q.almTime[rtc_pwr_pkg::SEC_POS +: 6]);
    fieldHit[1] = ~s_q.almMask[1] | (min == s_q.almTime[rtc_pwr_pkg::MIN_POS +: 6]);
    fieldHit[2] = ~s_q.almMask[2] | (hour == s_q.almTime[rtc_pwr_pkg::HOUR_POS +: 5]);
    fieldHit[3] = ~s_q.almMask[3] | (wday == s_q.almTime[rtc_pwr_pkg::WDAY_POS +: 3]);
    fieldHit[4] = ~s_q.almMask[4] | (date == s_q.almDate[rtc_pwr_pkg::DATE_POS +: 5]);
    fieldHit[5] = ~s_q.almMask[5] | (mon == s_q.almDate[rtc_pwr_pkg::MON_POS +: 4]);
    fieldHit[6] = ~s_q.almMask[6] | (year == s_q.almDate[rtc_pwr_pkg::YEAR_POS +: 7]);
    // An all-zero mask never matches
    match = (&fieldHit) & (|s_q.almMask);
  end

  // Supply decisions from the comparator levels
  always_comb begin
    if (s_q.lpSel) begin
      wantBackup = vddBelowBatLow;
      wantMain = vddAboveBatHigh;
    end else begin
      wantBackup = vddBelowBatLow & vddBelowTrip;
      wantMain = vddAboveBatHigh | vddAboveTripHigh;
    end
    // Only the condition for leaving the present mode counts
    wantChange = inBackup ? wantMain : wantBackup;
  end

  // Only word offsets in the table answer without error
  always_comb begin
    unique case (paddr)
      rtc_pwr_pkg::CTRL_OFF, rtc_pwr_pkg::STATUS_OFF, rtc_pwr_pkg::TIME_OFF,
      rtc_pwr_pkg::DATE_OFF, rtc_pwr_pkg::ALM_TIME_OFF, rtc_pwr_pkg::ALM_DATE_OFF,
      rtc_pwr_pkg::ALM_MASK_OFF: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end

  // Next state of everything the block remembers
  always_comb begin
    s_d = s_q;
    // Previous oscillator level for the edge detector
    s_d.oscPrev = oscillator_input;

    if (oscTick) begin
      if (!wantChange) begin
        s_d.filt = 8'h00;
      end else if (s_q.filt >= 8'(FILTER_LEN - 1)) begin
        // A change is only committed after the level held for the whole window
        s_d.filt = 8'h00;
        unique case (s_q.mode)
          rtc_pwr_pkg::MAIN_SUPPLY: s_d.mode = rtc_pwr_pkg::BACKUP_SUPPLY;
          rtc_pwr_pkg::BACKUP_SUPPLY: s_d.mode = rtc_pwr_pkg::MAIN_SUPPLY;
          default: s_d.mode = rtc_pwr_pkg::MAIN_SUPPLY;
        endcase
      end else begin
        s_d.filt = s_q.filt + 8'h01;
      end
    end

    // Gate follows the mode being entered, so backup never sees SDA driven
    nextBackup = (s_d.mode == rtc_pwr_pkg::BACKUP_SUPPLY);

    // Control and alarm register writes
    if (wrAcc) begin
      unique case (paddr)
        rtc_pwr_pkg::CTRL_OFF: begin
          // host keeps this write to main supply
          s_d.lpSel = pwdata[rtc_pwr_pkg::LP_SEL_POS];
          s_d.almEn = pwdata[rtc_pwr_pkg::ALM_EN_POS];
          s_d.repeatMode = pwdata[rtc_pwr_pkg::REPEAT_POS];
          s_d.pinOffBkp = pwdata[rtc_pwr_pkg::PIN_OFF_BKP_POS];
          s_d.freqSel = pwdata[rtc_pwr_pkg::FREQ_SEL_POS +: 4];
        end
        rtc_pwr_pkg::STATUS_OFF: begin
          if (pwdata[rtc_pwr_pkg::ST_LOSS_POS]) begin
            s_d.lossFlag = 1'b0;
          end
          if (pwdata[rtc_pwr_pkg::ST_ALARM_POS]) begin
            s_d.almFlag = 1'b0;
          end
        end
        rtc_pwr_pkg::ALM_TIME_OFF: s_d.almTime = pwdata[26:0];
        rtc_pwr_pkg::ALM_DATE_OFF: s_d.almDate = pwdata[22:0];
        rtc_pwr_pkg::ALM_MASK_OFF: s_d.almMask = pwdata[6:0];
        default: s_d.err = s_q.err;
      endcase
    end

    // A report in the clearing cycle wins
    // later loss report
    if (totalLossDetect) begin
      s_d.lossFlag = 1'b1;
    end

    // Match checked one cycle after the calendar stepped
    s_d.secSeen = secTick;
    // Pulse length counts oscillator ticks, not clocks
    if (s_q.pulseCnt != 16'h0000 && oscTick) begin
      s_d.pulseCnt = s_q.pulseCnt - 16'h0001;
    end
    if (s_q.secSeen) begin
      // A match lasts at least a second; only its start is an event
      s_d.lastMatch = match;
      // Alarm is parked while the pin serves as frequency output
      if (match && !s_q.lastMatch && s_q.almEn && s_q.freqSel == 4'h0) begin
        s_d.almFlag = 1'b1;
        if (s_q.repeatMode) begin
          s_d.pulseCnt = 16'(PULSE_TICKS);
        end
      end
    end

    s_d.sclGate = ~nextBackup;
    s_d.sdaOeN = ~(sdaPullFromCore & ~nextBackup);

    if (s_q.pinOffBkp && inBackup) begin
      s_d.pinOeN = 1'b1;
    end else if (s_q.freqSel != 4'h0) begin
      s_d.pinOeN = freqLevel;
    end else if (s_q.repeatMode) begin
      s_d.pinOeN = (s_q.pulseCnt == 16'h0000);
    end else begin
      s_d.pinOeN = ~s_q.almFlag;
    end

    // Read data captured in the setup phase for the access phase
    if (setupRd) begin
      s_d.err = ~addrOk;
      // Reserved bits read as zero, except gaps inside the alarm time and date words
      s_d.rdata = 32'h0000_0000;
      unique case (paddr)
        rtc_pwr_pkg::CTRL_OFF: begin
          s_d.rdata[rtc_pwr_pkg::LP_SEL_POS] = s_q.lpSel;
          s_d.rdata[rtc_pwr_pkg::ALM_EN_POS] = s_q.almEn;
          s_d.rdata[rtc_pwr_pkg::REPEAT_POS] = s_q.repeatMode;
          s_d.rdata[rtc_pwr_pkg::PIN_OFF_BKP_POS] = s_q.pinOffBkp;
          s_d.rdata[rtc_pwr_pkg::FREQ_SEL_POS +: 4] = s_q.freqSel;
        end
        rtc_pwr_pkg::STATUS_OFF: begin
          s_d.rdata[rtc_pwr_pkg::ST_BACKUP_POS] = inBackup;
          s_d.rdata[rtc_pwr_pkg::ST_LOSS_POS] = s_q.lossFlag;
          s_d.rdata[rtc_pwr_pkg::ST_ALARM_POS] = s_q.almFlag;
          s_d.rdata[rtc_pwr_pkg::ST_TRIP_ON_POS] = ~s_q.lpSel;
        end
        rtc_pwr_pkg::TIME_OFF: s_d.rdata = timeWord;
        rtc_pwr_pkg::DATE_OFF: s_d.rdata = dateWord;
        rtc_pwr_pkg::ALM_TIME_OFF: s_d.rdata[26:0] = s_q.almTime;
        rtc_pwr_pkg::ALM_DATE_OFF: s_d.rdata[22:0] = s_q.almDate;
        rtc_pwr_pkg::ALM_MASK_OFF: s_d.rdata[6:0] = s_q.almMask;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Single register stage for the whole block state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= rtc_pwr_pkg::MAIN_SUPPLY;
      {s_q.freqSel, s_q.pinOffBkp, s_q.repeatMode, s_q.almEn, s_q.lpSel} <=
        rtc_pwr_pkg::CTRL_RESET;
      s_q.lossFlag <= 1'b1;
      // Serial and pin drivers start released
      s_q.sdaOeN <= 1'b1;
      s_q.pinOeN <= 1'b1;
      s_q.sclGate <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tripMonitorEnable = ~s_q.lpSel;
  assign backupMode = inBackup;

  assign sclToCore = sclIn | ~s_q.sclGate;
  assign sdaToCore = sdaIn | ~s_q.sclGate;
  assign sdaOut = 1'b0;
  assign sdaOeN = s_q.sdaOeN;

  // Open drain: only ever pulls low
  assign alarm_or_freq_pinOut = 1'b0;
  assign alarm_or_freq_pinOeN = s_q.pinOeN;

  // No wait states; error only for unmapped words
  // A refused write changes nothing; pslverr is the only sign
  assign pready = 1'b1;
  assign pslverr = psel & penable & s_q.err;
  assign prdata = s_q.rdata;
endmodule
`default_nettype wire

// File: bench/supply_partner.sv
// Purpose: Supply comparators and time base facing the power mode block
// Assumes: Supply levels are given in millivolts by the bench
// Notes: Thresholds are plain defaults; the clock input toggles every cycle
`default_nettype none
module supply_partner #(
  parameter int TRIP_MV = 2200,
  parameter int TRIP_HYS_MV = 30,
  parameter int BAT_HYS_MV = 50
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] vddMv,
  input wire logic [15:0] vbatMv,
  output logic oscillator_input,
  output logic vddBelowBatLow,
  output logic vddAboveBatHigh,
  output logic vddBelowTrip,
  output logic vddAboveTripHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal comparators; analog noise is not modelled
  assign vddBelowBatLow = (int'(vddMv) + BAT_HYS_MV) < int'(vbatMv);
  assign vddAboveBatHigh = int'(vddMv) > (int'(vbatMv) + BAT_HYS_MV);
  assign vddBelowTrip = int'(vddMv) < TRIP_MV;
  assign vddAboveTripHigh = int'(vddMv) > (TRIP_MV + TRIP_HYS_MV);
  always @(posedge clock) begin
    if (!rst_n) begin
      oscillator_input <= 1'b0;
    end else begin
      oscillator_input <= ~oscillator_input; // Fast stand-in keeps seconds short
    end
  end
endmodule
`default_nettype wire

// File: bench/rtc_backup_power_checker.sv
// Purpose: Port-level assertions for the backup power mode block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Serial gate checks hold in every cycle the mode is backup
`default_nettype none
module rtc_backup_power_checker #(
  parameter int PULSE_TICKS = 4,
  parameter int FILTER_LEN = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vddBelowBatLow,
  input wire logic vddAboveBatHigh,
  input wire logic vddBelowTrip,
  input wire logic vddAboveTripHigh,
  input wire logic tripMonitorEnable,
  input wire logic backupMode,
  input wire logic sclToCore,
  input wire logic sdaToCore,
  input wire logic sdaPullFromCore,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic alarm_or_freq_pinOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic badAddr;
  logic lpBit;
  // Unmapped offsets and the low-power select bit of a write
  assign badAddr = (paddr[1:0] != 2'h0) || (paddr > 8'h18);
  assign lpBit = pwdata[rtc_pwr_pkg::LP_SEL_POS];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence accessPhase;
    psel && penable;
  endsequence
  sequence ctrlWrite;
    accessPhase ##0 (pwrite && paddr == rtc_pwr_pkg::CTRL_OFF);
  endsequence
  a_ready_always: assert property (pready) else $error("pready low");
  a_bad_addr: assert property (accessPhase ##0 (badAddr && !pwrite) |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_good_addr: assert property (accessPhase ##0 !badAddr |-> !pslverr)
    else $error("mapped access refused");
  a_trip_follow: assert property (ctrlWrite |=> tripMonitorEnable == !$past(lpBit))
    else $error("trip monitor not following select");
  a_scl_gated: assert property (backupMode |-> sclToCore && sdaToCore)
    else $error("serial inputs not gated");
  a_sda_quiet: assert property (backupMode |-> sdaOeN)
    else $error("data driven in backup");
  a_sda_follow: assert property ($past(rst_n) && $past(rst_n, 2) && !backupMode
    && !$past(backupMode) && !$past(backupMode, 2) |-> sdaOeN == !$past(sdaPullFromCore))
    else $error("data enable not following core");
  a_enter_cause: assert property ($rose(backupMode) |-> $past(vddBelowBatLow)
    && ($past(vddBelowTrip) || !$past(tripMonitorEnable))) else $error("backup without cause");
  a_leave_cause: assert property ($fell(backupMode) |-> $past(vddAboveBatHigh)
    || ($past(vddAboveTripHigh) && $past(tripMonitorEnable))) else $error("main without cause");
  a_open_drain: assert property (sdaOut == 1'b0 && alarm_or_freq_pinOut == 1'b0)
    else $error("open drain data not low");
endmodule
bind rtc_backup_power rtc_backup_power_checker #(.PULSE_TICKS(PULSE_TICKS),
  .FILTER_LEN(FILTER_LEN)) pwrChk (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .vddBelowBatLow, .vddAboveBatHigh, .vddBelowTrip,
  .vddAboveTripHigh, .tripMonitorEnable, .backupMode, .sclToCore, .sdaToCore,
  .sdaPullFromCore, .sdaOut, .sdaOeN, .alarm_or_freq_pinOut);
`default_nettype wire

// File: bench/testbench.sv
// Purpose: Self-checking bench for the backup power mode block
// Assumes: Zero wait APB slave; short filter and pulse counts
// Notes: One second lasts 65536 clocks with the time base used here
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, psel, penable, pwrite, totalLossDetect, sclIn, hostSda;
  logic sdaPullFromCore, pready, pslverr, oscillator_input, vddBelowBatLow, vddAboveBatHigh;
  logic vddBelowTrip, vddAboveTripHigh, tripMonitorEnable, backupMode, sclToCore, sdaToCore;
  logic sdaOut, sdaOeN, alarm_or_freq_pinOut, alarm_or_freq_pinOeN, sdaLine, pinPrev;
  logic [7:0] paddr;
  logic [15:0] vddMv, vbatMv;
  logic [31:0] pwdata, prdata, rd;
  int err_total, checks, cnt;
  // Pulled-up data wire, low when any party pulls
  assign sdaLine = hostSda & sdaOeN;
  rtc_backup_power #(.PULSE_TICKS(4), .FILTER_LEN(2)) dut (.clock, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscillator_input, .vddBelowBatLow,
    .vddAboveBatHigh, .vddBelowTrip, .vddAboveTripHigh, .totalLossDetect, .tripMonitorEnable,
    .backupMode, .sclIn, .sdaIn(sdaLine), .sdaPullFromCore, .sclToCore, .sdaToCore, .sdaOut,
    .sdaOeN, .alarm_or_freq_pinOut, .alarm_or_freq_pinOeN);
  supply_partner sp (.clock, .rst_n, .vddMv, .vbatMv, .oscillator_input, .vddBelowBatLow,
    .vddAboveBatHigh, .vddBelowTrip, .vddAboveTripHigh);
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    cnt = int'(pslverr === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic supply(input int mv);
    @(posedge clock);
    vddMv <= mv[15:0];
  endtask
  // Bounded wait on the mode (sel 0) or the shared pin enable (sel 1)
  task automatic waitFor(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? backupMode : alarm_or_freq_pinOeN) !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic t_reset;
    apb(1'b0, rtc_pwr_pkg::STATUS_OFF, 32'h0);
    chk("status", rd, 32'h0000000A);
    apb(1'b0, rtc_pwr_pkg::CTRL_OFF, 32'h0);
    chk("ctrl", rd, 32'h0);
    chk("tripmon", tripMonitorEnable, 32'h1);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", {rd[30:0], cnt[0]}, 32'h1);
  endtask
  task automatic t_normal;
    supply(2500);
    repeat (40) @(posedge clock);
    chk("above trip", backupMode, 32'h0);
    supply(2000);
    sdaPullFromCore <= 1'b1;
    sclIn <= 1'b0;
    waitFor(0, 1'b1, 60);
    repeat (3) @(posedge clock);
    chk("enter", backupMode, 32'h1);
    chk("scl gated", sclToCore, 32'h1);
    chk("sda line", sdaLine, 32'h1);
    apb(1'b0, rtc_pwr_pkg::STATUS_OFF, 32'h0);
    chk("status bkp", rd, 32'h0000000B);
    supply(2240);
    waitFor(0, 1'b0, 60);
    repeat (3) @(posedge clock);
    chk("leave trip", backupMode, 32'h0);
    chk("sda pulled", sdaLine, 32'h0);
    sdaPullFromCore <= 1'b0;
    sclIn <= 1'b1;
    supply(3100);
  endtask
  // Host writes control only with the main supply above backup
  task automatic t_lowpower;
    apb(1'b1, rtc_pwr_pkg::CTRL_OFF, 32'h1);
    @(posedge clock);
    chk("trip off", tripMonitorEnable, 32'h0);
    supply(2500);
    waitFor(0, 1'b1, 60);
    chk("lp enter", backupMode, 32'h1);
    supply(2240);
    repeat (40) @(posedge clock);
    chk("trip ignored", backupMode, 32'h1);
    supply(3100);
    waitFor(0, 1'b0, 60);
    chk("lp leave", backupMode, 32'h0);
    apb(1'b1, rtc_pwr_pkg::CTRL_OFF, 32'h0);
    @(posedge clock);
    chk("trip on", tripMonitorEnable, 32'h1);
  endtask
  task automatic t_loss;
    apb(1'b1, rtc_pwr_pkg::STATUS_OFF, 32'h2);
    apb(1'b0, rtc_pwr_pkg::STATUS_OFF, 32'h0);
    chk("loss clr", rd, 32'h8);
    totalLossDetect <= 1'b1;
    @(posedge clock);
    totalLossDetect <= 1'b0;
    apb(1'b0, rtc_pwr_pkg::STATUS_OFF, 32'h0);
    chk("loss set", rd, 32'hA);
  endtask
  task automatic t_freq;
    apb(1'b1, rtc_pwr_pkg::CTRL_OFF, 32'h10);
    // Pin follows the oscillator, which flips every clock here
    cnt = 0;
    pinPrev = alarm_or_freq_pinOeN;
    repeat (16) begin
      @(posedge clock);
      cnt += int'(alarm_or_freq_pinOeN !== pinPrev);
      pinPrev = alarm_or_freq_pinOeN;
    end
    chk("fout toggles", 32'(cnt >= 12), 32'h1);
    apb(1'b1, rtc_pwr_pkg::CTRL_OFF, 32'h0);
    waitFor(1, 1'b1, 10);
    chk("fout off", alarm_or_freq_pinOeN, 32'h1);
  endtask
  // The alarm fires while on backup, so timekeeping there is exercised
  task automatic t_alarm;
    apb(1'b1, rtc_pwr_pkg::TIME_OFF, 32'h0);
    apb(1'b1, rtc_pwr_pkg::ALM_TIME_OFF, 32'h1);
    apb(1'b1, rtc_pwr_pkg::ALM_MASK_OFF, 32'h1);
    apb(1'b1, rtc_pwr_pkg::CTRL_OFF, 32'h2);
    supply(2000);
    waitFor(0, 1'b1, 60);
    waitFor(1, 1'b0, 70000);
    chk("alarm pin", alarm_or_freq_pinOeN, 32'h0);
    supply(3100);
    waitFor(0, 1'b0, 60);
    apb(1'b0, rtc_pwr_pkg::STATUS_OFF, 32'h0);
    chk("alarm flag", rd & 32'h4, 32'h4);
    apb(1'b0, rtc_pwr_pkg::TIME_OFF, 32'h0);
    chk("seconds", rd & 32'h3F, 32'h1);
    apb(1'b1, rtc_pwr_pkg::STATUS_OFF, 32'h4);
    waitFor(1, 1'b1, 20);
    chk("pin free", alarm_or_freq_pinOeN, 32'h1);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cuts a hang short; the run needs about 66000 cycles
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    wrap_up();
  end
  initial begin
    {rst_n, psel, penable, pwrite, totalLossDetect, sdaPullFromCore} = 6'h00;
    {sclIn, hostSda} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    vddMv = 16'h0C1C;
    vbatMv = 16'h0BB8;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_normal();
    t_lowpower();
    t_loss();
    t_freq();
    t_alarm();
    wrap_up();
  end
endmodule
`default_nettype wire
